// ===== design/via_ctrl.sv
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module via_ctrl
#(
  parameter int          NUM_SRC  = via_pkg::NUM_SRC,
  parameter logic [15:0] NMI_VEC  = 16'h0004
)
(
  // Clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // Request sources
  input  wire logic [NUM_SRC-1:0]          src_req,
  input  wire logic                        nmi_req,
  // Instruction sequencer
  input  wire logic                        seq_boundary,
  input  wire logic                        seq_defer,
  input  wire logic                        seq_interrupt_return_instr,
  input  wire logic                        seq_break_return_instr,
  input  wire logic                        seq_brk,
  input  wire logic                        seq_ei,
  input  wire logic                        seq_di,
  input  wire logic                        seq_psw_load,
  input  wire logic [1:0]                  seq_psw_val,
  // Service start to sequencer
  output logic                             svc_start,
  output logic [15:0]                      svc_vector,
  output via_pkg::via_kind_e               svc_kind,
  output logic [via_pkg::IDX_W-1:0]        svc_src,
  output logic                             global_irq_enable,
  output logic                             in_service_priority,
  // AXI4-Lite slave
  input  wire logic [7:0]                  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [7:0]                  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready
);
  import via_pkg::*;

  // Lowest set index of a vector, with a found bit on top
  function automatic logic [IDX_W:0] pick_first(input logic [NUM_SRC-1:0] v);
    logic [IDX_W:0] r;
    r = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, IDX_W'(i)};
      end
    end
    return r;
  endfunction

  // Offset decode shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    logic [2:0] s;
    s = 3'h4;
    unique case (a)
      OFS_REQ:  s = 3'h0;
      OFS_MASK: s = 3'h1;
      OFS_PRIO: s = 3'h2;
      OFS_STAT: s = 3'h3;
      default:  s = 3'h4;
    endcase
    return s;
  endfunction

  // Flag registers and status word bits
  logic [NUM_SRC-1:0] req_ff;          // source_request_flag
  logic [NUM_SRC-1:0] mask_ff;         // source_mask_flag
  logic [NUM_SRC-1:0] prio_ff;         // source_priority_flag
  logic [NUM_SRC-1:0] nxt_req;
  logic [NUM_SRC-1:0] nxt_mask;
  logic [NUM_SRC-1:0] nxt_prio;
  logic               ie_ff;           // global_irq_enable
  logic               isp_ff;          // in_service_priority
  logic               nmi_pend_ff;     // One pending non-maskable
  logic               nmi_active_ff;   // Non-maskable handler running
  // Save sequence
  via_state_e         state_ff;
  logic [CNT_W-1:0]   cnt_ff;
  logic               svc_start_ff;
  logic [15:0]        svc_vector_ff;
  via_kind_e          svc_kind_ff;
  logic [IDX_W-1:0]   svc_src_ff;
  // Bus slave
  logic               awready_ff;
  logic               wready_ff;
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic [7:0]         awaddr_ff;
  logic [31:0]        wdata_ff;
  logic [3:0]         wstrb_ff;
  logic               arready_ff;
  logic               rvalid_ff;
  logic [1:0]         rresp_ff;
  logic [31:0]        rdata_ff;
  // Arbitration terms
  logic [NUM_SRC-1:0] elig;
  logic [NUM_SRC-1:0] elig_hi;
  logic [NUM_SRC-1:0] elig_lo;
  logic [IDX_W:0]     pick_hi;
  logic [IDX_W:0]     pick_lo;
  logic [IDX_W-1:0]   win_idx;
  logic               win_lo;
  logic               defer_now;
  logic               can_acc;
  logic               acc_brk;
  logic               acc_nmi;
  logic               acc_mask;
  logic               wr_go;
  logic [2:0]         wr_sel;
  logic [31:0]        wr_bits;
  logic [31:0]        cur_word;

  // Defer on the defer strobe, both returns, status load and DI; EI does not defer
  // deferring instruction set
  assign defer_now = seq_defer | seq_interrupt_return_instr | seq_break_return_instr | seq_psw_load
                   | seq_di;

  // Decide only at a boundary, never while a save is running
  // boundary-only evaluation
  assign can_acc = seq_boundary & ~defer_now & (state_ff == ST_IDLE);

  // Eligibility and two-level selection
  // request, mask and level gates
  assign elig    = req_ff & ~mask_ff;
  assign elig_hi = elig & ~prio_ff;
  assign elig_lo = elig & prio_ff & {NUM_SRC{isp_ff}};
  assign pick_hi = pick_first(elig_hi);
  assign pick_lo = pick_first(elig_lo);
  assign win_lo  = ~pick_hi[IDX_W];
  assign win_idx = win_lo ? pick_lo[IDX_W-1:0] : pick_hi[IDX_W-1:0];

  // Break is taken at its own boundary, ahead of everything else
  // break cannot be disabled
  assign acc_brk  = can_acc & seq_brk;
  assign acc_nmi  = can_acc & ~seq_brk & nmi_pend_ff & ~nmi_active_ff;
  assign acc_mask = can_acc & ~seq_brk & ~acc_nmi & ie_ff & ~nmi_active_ff
                  & (pick_hi[IDX_W] | pick_lo[IDX_W]);

  // Write strobe expansion and register write decode
  assign wr_go  = ~awready_ff & ~wready_ff & ~bvalid_ff;
  assign wr_sel = reg_sel(awaddr_ff);
  generate
    for (genvar b = 0; b < 4; b++)
    begin : g_strb
      assign wr_bits[b*8 +: 8] = {8{wstrb_ff[b]}};
    end
  endgenerate
  always_comb
  begin
    cur_word = '0;
    unique case (wr_sel)
      3'h0:    cur_word = 32'(req_ff);
      3'h1:    cur_word = 32'(mask_ff);
      3'h2:    cur_word = 32'(prio_ff);
      default: cur_word = '0;
    endcase
    cur_word = (cur_word & ~wr_bits) | (wdata_ff & wr_bits);
  end

  // Request flags: write, clear on accept, then sources set
  always_comb
  begin
    nxt_req = req_ff;
    if (wr_go && wr_sel == 3'h0)
    begin
      nxt_req = cur_word[NUM_SRC-1:0];
    end
    if (acc_mask)
    begin
      nxt_req[win_idx] = 1'b0;
    end
    nxt_req = nxt_req | src_req;
  end

  // Mask and priority flags are software-only
  always_comb
  begin
    nxt_mask = mask_ff;
    nxt_prio = prio_ff;
    if (wr_go && wr_sel == 3'h1)
    begin
      nxt_mask = cur_word[NUM_SRC-1:0];
    end
    if (wr_go && wr_sel == 3'h2)
    begin
      nxt_prio = cur_word[NUM_SRC-1:0];
    end
  end

  // Flag register update
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_ff  <= '0;
      mask_ff <= RST_ONES[NUM_SRC-1:0];
      prio_ff <= RST_ONES[NUM_SRC-1:0];
    end
    else
    begin
      req_ff  <= nxt_req;
      mask_ff <= nxt_mask;
      prio_ff <= nxt_prio;
    end
  end

  // Non-maskable pending bit; a new request wins over the clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_pend_ff <= 1'b0;
    end
    else if (nmi_req)
    begin
      nmi_pend_ff <= 1'b1;
    end
    else if (acc_nmi)
    begin
      nmi_pend_ff <= 1'b0;
    end
  end

  // Non-maskable handler tracking; return ends it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      nmi_active_ff <= 1'b0;
    end
    else if (acc_nmi)
    begin
      nmi_active_ff <= 1'b1;
    end
    else if (seq_boundary && seq_interrupt_return_instr)
    begin
      nmi_active_ff <= 1'b0;
    end
  end

  // Enable and service priority flags of the status word
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ie_ff  <= RST_IE;
      isp_ff <= RST_ISP;
    end
    else if (acc_nmi)
    begin
      ie_ff  <= 1'b0;
      isp_ff <= 1'b0;
    end
    else if (acc_mask)
    begin
      ie_ff  <= 1'b0;
      isp_ff <= prio_ff[win_idx];
    end
    else if (acc_brk)
    begin
      ie_ff <= 1'b0;
    end
    else if (seq_boundary && seq_psw_load)
    begin
      ie_ff  <= seq_psw_val[1];
      isp_ff <= seq_psw_val[0];
    end
    else if (seq_boundary && seq_ei)
    begin
      ie_ff <= 1'b1;
    end
    else if (seq_boundary && seq_di)
    begin
      ie_ff <= 1'b0;
    end
  end

  // Save-and-vector sequence; the sequencer pushes status then PC
  // fixed save span sets least latency
  // longest latency is set by instruction length
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_ff      <= ST_IDLE;
      cnt_ff        <= '0;
      svc_start_ff  <= 1'b0;
      svc_vector_ff <= '0;
      svc_kind_ff   <= KIND_NMI;
      svc_src_ff    <= '0;
    end
    else
    begin
      svc_start_ff <= 1'b0;
      unique case (state_ff)
        ST_IDLE:
        begin
          if (acc_brk || acc_nmi || acc_mask)
          begin
            state_ff <= ST_SAVE;
            cnt_ff   <= (acc_mask && win_lo) ? CNT_W'(SAVE_CNT_LO)
                                             : CNT_W'(SAVE_CNT_HI);
          end
          if (acc_brk)
          begin
            svc_vector_ff <= VEC_BRK;
            svc_kind_ff   <= KIND_BRK;
          end
          else if (acc_nmi)
          begin
            svc_vector_ff <= NMI_VEC;
            svc_kind_ff   <= KIND_NMI;
          end
          else if (acc_mask)
          begin
            svc_vector_ff <= VEC_BASE + {10'h000, win_idx, 1'b0};
            svc_kind_ff   <= KIND_MASK;
            svc_src_ff    <= win_idx;
          end
        end
        ST_SAVE:
        begin
          if (cnt_ff == '0)
          begin
            state_ff     <= ST_IDLE;
            svc_start_ff <= 1'b1;
          end
          else
          begin
            cnt_ff <= cnt_ff - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // Write channel: address and data in either order, then response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && awready_ff)
      begin
        awready_ff <= 1'b0;
        awaddr_ff  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff)
      begin
        wready_ff <= 1'b0;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      // Unmapped offsets answer with an error; status writes are ignored
      if (wr_go)
      begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (wr_sel == 3'h4) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_ff && s_axi_bready)
      begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // Read channel: one read at a time, data registered
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
    end
    else if (s_axi_arvalid && arready_ff)
    begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      rdata_ff   <= '0;
      unique case (reg_sel(s_axi_araddr))
        3'h0: rdata_ff <= 32'(req_ff);
        3'h1: rdata_ff <= 32'(mask_ff);
        3'h2: rdata_ff <= 32'(prio_ff);
        3'h3:
        begin
          rdata_ff[STAT_IE]   <= ie_ff;
          rdata_ff[STAT_ISP]  <= isp_ff;
          rdata_ff[STAT_NMIA] <= nmi_active_ff;
          rdata_ff[STAT_NMIP] <= nmi_pend_ff;
          rdata_ff[STAT_BUSY] <= (state_ff == ST_SAVE);
        end
        default: rresp_ff <= RESP_SLVERR;
      endcase
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // Outputs straight from flops
  assign svc_start           = svc_start_ff;
  assign svc_vector          = svc_vector_ff;
  assign svc_kind            = svc_kind_ff;
  assign svc_src             = svc_src_ff;
  assign global_irq_enable   = ie_ff;
  assign in_service_priority = isp_ff;
  assign s_axi_awready       = awready_ff;
  assign s_axi_wready        = wready_ff;
  assign s_axi_bvalid        = bvalid_ff;
  assign s_axi_bresp         = bresp_ff;
  assign s_axi_arready       = arready_ff;
  assign s_axi_rvalid        = rvalid_ff;
  assign s_axi_rresp         = rresp_ff;
  assign s_axi_rdata         = rdata_ff;

  // Checks on the acceptance logic
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_nmi_first: assert property (
    can_acc && !seq_brk && nmi_pend_ff && !nmi_active_ff
    |=> svc_kind_ff == KIND_NMI)
    else $error("maskable taken over pending non-maskable");
  a_nmi_flags: assert property (
    acc_nmi |=> !ie_ff && !isp_ff && svc_vector_ff == NMI_VEC)
    else $error("non-maskable accept did not clear flags");
  a_nmi_nonest: assert property (
    nmi_active_ff && !seq_brk && state_ff == ST_IDLE
    |=> state_ff == ST_IDLE)
    else $error("interrupt nested into non-maskable handler");
  a_mask_gate: assert property (
    acc_mask |-> req_ff[win_idx] && !mask_ff[win_idx] && ie_ff
                 && (!prio_ff[win_idx] || isp_ff))
    else $error("ineligible maskable accepted");
  a_isp_copy: assert property (
    acc_mask |=> !ie_ff && isp_ff == $past(prio_ff[win_idx]))
    else $error("service priority not copied");
  a_hi_level: assert property (
    acc_mask && (elig_hi != '0) |-> !prio_ff[win_idx])
    else $error("low level chosen over high level");
  a_defer_hold: assert property (
    seq_boundary && defer_now && state_ff == ST_IDLE
    |=> state_ff == ST_IDLE)
    else $error("accepted after deferring instruction");
  a_hi_latency: assert property (
    acc_mask && !win_lo |-> ##6 svc_start_ff)
    else $error("high level save span wrong");
  a_lo_latency: assert property (
    acc_mask && win_lo |-> !svc_start_ff [*7] ##1 svc_start_ff)
    else $error("low level save span wrong");
  a_brk_vector: assert property (
    acc_brk |=> !ie_ff && svc_kind_ff == KIND_BRK
                && svc_vector_ff == VEC_BRK)
    else $error("break vector or enable wrong");
  a_flag_clear: assert property (
    acc_mask && !src_req[win_idx] && !wr_go |=> !req_ff[$past(win_idx)])
    else $error("request flag not cleared on accept");
endmodule

// ===== design/via_pkg.sv
package via_pkg;
  // Source count and index width
  localparam int NUM_SRC   = 27;
  localparam int IDX_W     = 5;
  // Register byte offsets on the bus
  localparam logic [7:0] OFS_REQ  = 8'h00;
  localparam logic [7:0] OFS_MASK = 8'h04;
  localparam logic [7:0] OFS_PRIO = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  // Status register bit positions
  localparam int STAT_IE   = 0;
  localparam int STAT_ISP  = 1;
  localparam int STAT_NMIA = 2;
  localparam int STAT_NMIP = 3;
  localparam int STAT_BUSY = 4;
  // Status word flag reset values
  localparam logic RST_IE  = 1'b0;
  localparam logic RST_ISP = 1'b1;
  // Mask and priority flags reset to all ones
  localparam logic [31:0] RST_ONES = 32'hFFFFFFFF;
  // Vector table
  localparam logic [15:0] VEC_BRK  = 16'h003E;
  localparam logic [15:0] VEC_BASE = 16'h0004;
  // Request-to-service latency in CPU clocks
  localparam int CLK_NS     = 10;
  localparam int LAT_HI_MIN = 7;
  localparam int LAT_LO_MIN = 8;
  localparam int LAT_HI_MAX = 32;
  localparam int LAT_LO_MAX = 33;
  // Save-sequence counts: request flag, accept edge and start flop take 3 clocks
  localparam int SAVE_CNT_HI = LAT_HI_MIN - 3;
  localparam int SAVE_CNT_LO = LAT_LO_MIN - 3;
  localparam int CNT_W       = 5;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SAVE = 1'b1
  } via_state_e;
  // Kind of accepted interrupt
  typedef enum logic [1:0] {
    KIND_NMI  = 2'b00,
    KIND_MASK = 2'b01,
    KIND_BRK  = 2'b10
  } via_kind_e;
endpackage

// ===== verif/via_seq_model.sv
`timescale 1ns/1ns
// Sequencer stand-in: one completed instruction for each op_go pulse
module via_seq_model
  import via_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Op from bench: 0 plain 1 defer 2 return 3 break 4 ei 5 di
  input  wire logic       op_go,
  input  wire logic [2:0] op,
  // Block state
  input  wire logic       svc_start,
  input  wire logic [1:0] svc_kind,
  input  wire logic       global_irq_enable,
  input  wire logic       in_service_priority,
  // Sequencer strobes
  output logic            seq_boundary,
  output logic            seq_defer,
  output logic            seq_interrupt_return_instr,
  output logic            seq_break_return_instr,
  output logic            seq_brk,
  output logic            seq_ei,
  output logic            seq_di,
  output logic            seq_psw_load,
  output logic [1:0]      seq_psw_val
);
  logic [9:0] o_r = 10'h000; // Strobe bundle, quiet from time zero
  logic [1:0] pre_ff = 2'h3; // Flags seen at the last boundary
  logic [3:0] stk_q[$];      // Kind and saved flags per open handler
  logic [3:0] top;           // Entry taken off at a return
  assign {seq_boundary, seq_defer, seq_interrupt_return_instr, seq_break_return_instr, seq_brk, seq_ei,
          seq_di, seq_psw_load, seq_psw_val} = o_r;
  // Boundary one cycle after each op; a return reloads the saved flags
  always @(posedge aclk)
  begin
    o_r <= {op_go, op_go && op == 3'h1, 2'h0, op_go && op == 3'h3,
            op_go && op == 3'h4, op_go && op == 3'h5, 1'b0, o_r[1:0]};
    if (seq_boundary)
      pre_ff <= {global_irq_enable, in_service_priority};
    if (svc_start)
      stk_q.push_back({svc_kind, pre_ff});
    // break handler left by break return
    if (op_go && op == 3'h2 && stk_q.size() != 0)
    begin
      top = stk_q.pop_back();
      o_r[7:6] <= {top[3:2] != KIND_BRK, top[3:2] == KIND_BRK};
      o_r[2:0] <= {1'b1, top[1:0]};
    end
    // Reset forgets open handlers
    if (!aresetn)
      stk_q.delete();
  end
endmodule

// ===== verif/via_ctrl_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) \
  begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module vectored_interrupt_acknowledge_tb_top;
  import via_pkg::*;
  // Expected service start
  typedef struct packed {
    logic [15:0] v;
    logic [1:0]  k;
    logic [4:0]  s;
    logic [31:0] t;
  } via_note_s;
  localparam logic [15:0] NMI_V = 16'h0002;    // Non-maskable vector
  localparam logic [31:0] PRIO = 32'h02AAAAAA; // Odd sources low level
  localparam logic [31:0] ALL = 32'h07FFFFFF;  // Implemented flag bits
  localparam logic [2:0] OP_PLN = 3'h0, OP_DEF = 3'h1, OP_RET = 3'h2;
  localparam logic [2:0] OP_BRK = 3'h3, OP_EI = 3'h4, OP_DI = 3'h5;
  logic aclk = 1'b0, aresetn = 1'b0, nmi_req = 1'b0, op_go = 1'b0;
  logic [26:0] src_req = '0;
  logic [2:0] op = 3'h0;
  logic seq_boundary, seq_defer, seq_interrupt_return_instr, seq_break_return_instr, seq_brk, seq_ei;
  logic seq_di, seq_psw_load, svc_start, global_irq_enable;
  logic in_service_priority;
  logic [1:0] seq_psw_val, s_axi_bresp, s_axi_rresp;
  logic [15:0] svc_vector;
  via_kind_e svc_kind;
  logic [4:0] svc_src;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, cyc = '0;
  logic [3:0] s_axi_wstrb = 4'hF; // Whole words only
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  via_note_s exp_q[$], nt;     // Pending service notes
  logic [33:0] rd_q[$], rx;    // Pending read answers
  logic [1:0] wr_q[$], bx;     // Pending write answers
  int error_cnt = 0, n_tests = 0, idx;

  via_ctrl #(.NMI_VEC(NMI_V)) i_dut (.aclk, .aresetn, .src_req, .nmi_req,
    .seq_boundary, .seq_defer, .seq_interrupt_return_instr, .seq_break_return_instr, .seq_brk, .seq_ei,
    .seq_di, .seq_psw_load, .seq_psw_val, .svc_start, .svc_vector,
    .svc_kind, .svc_src, .global_irq_enable, .in_service_priority,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  via_seq_model i_seq (.aclk, .aresetn, .op_go, .op, .svc_start,
    .svc_kind, .global_irq_enable, .in_service_priority, .seq_boundary,
    .seq_defer, .seq_interrupt_return_instr, .seq_break_return_instr, .seq_brk, .seq_ei, .seq_di,
    .seq_psw_load, .seq_psw_val);

  // 100 MHz clock
  initial
  begin
    forever #5 aclk = ~aclk;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic hang();
    error_cnt++;
    stop_test();
  endtask

  // Bus write; the answer is checked by the monitor
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    int n;
    n = 0;
    wr_q.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50)
      hang();
  endtask

  // Bus read; the answer is checked by the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r = RESP_OKAY);
    int n;
    n = 0;
    rd_q.push_back({r, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50)
      hang();
  endtask

  // Requests plus one instruction; lat nonzero notes a service start
  task automatic step(input logic [26:0] q, input logic n,
    input logic [2:0] o, input logic [15:0] v = 16'h0,
    input logic [1:0] k = 2'h0, input int s = 0, input int lat = 0);
    @(posedge aclk);
    if (lat != 0)
      exp_q.push_back({v, k, 5'(s), cyc + 32'(lat) + 32'h1});
    src_req <= q;
    nmi_req <= n;
    op <= o;
    op_go <= 1'b1;
    @(posedge aclk);
    src_req <= '0;
    nmi_req <= 1'b0;
    op_go <= 1'b0;
    // Longer than any save span, so no boundary lands while busy
    repeat (12) @(posedge aclk);
  endtask
  task automatic mreq(input logic [26:0] q, input int s);
    step(q, 1'b0, OP_PLN, VEC_BASE + 16'(2 * s), KIND_MASK, s,
         PRIO[s] ? LAT_LO_MIN : LAT_HI_MIN);
  endtask

  // Monitor: oldest note against each result as it appears
  always @(posedge aclk)
  begin
    cyc <= cyc + 32'h1;
    if (svc_start)
    begin
      nt = exp_q.size() != 0 ? exp_q.pop_front() : '0;
      `CHK(svc_vector, nt.v)
      `CHK(svc_kind, nt.k)
      `CHK(cyc, nt.t)
      if (nt.k == KIND_MASK)
        `CHK(svc_src, nt.s)
      `CHK(global_irq_enable, 1'b0)
      if (nt.k != KIND_BRK)
        `CHK(in_service_priority, nt.k == KIND_MASK && PRIO[nt.s])
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rx = rd_q.pop_front();
      `CHK({s_axi_rresp, s_axi_rdata}, rx)
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bx = wr_q.pop_front();
      `CHK(s_axi_bresp, bx)
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(64));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_REQ, 32'h0);
    rd(OFS_MASK, ALL);
    rd(OFS_PRIO, ALL);
    rd(OFS_STAT, 32'h2);
    rd(8'h10, 32'h0, RESP_SLVERR);
    axw(8'h10, 32'h1, RESP_SLVERR);
    axw(OFS_STAT, 32'h1, RESP_OKAY);
    rd(OFS_STAT, 32'h2);
    axw(OFS_PRIO, PRIO, RESP_OKAY);
    rd(OFS_PRIO, PRIO);
    step(27'h10, 1'b0, OP_PLN);
    rd(OFS_REQ, 32'h10);
    step(27'h0, 1'b0, OP_EI);
    rd(OFS_STAT, 32'h3);
    axw(OFS_MASK, 32'h0, RESP_OKAY);
    mreq(27'h0, 4);
    rd(OFS_REQ, 32'h0);
    rd(OFS_STAT, 32'h0);
    // Nesting inside a high-level handler
    step(27'h0, 1'b0, OP_EI);
    step(27'h2, 1'b0, OP_PLN);
    mreq(27'h40, 6);
    step(27'h0, 1'b0, OP_RET);
    step(27'h0, 1'b0, OP_PLN);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h0, 1);
    step(27'h0, 1'b0, OP_RET);
    // Level first, then fixed order
    mreq(27'h1480, 10);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h0, 12);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h0, 7);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h4000001, 0);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h0, 26);
    step(27'h0, 1'b0, OP_RET);
    // Deferring instructions
    step(27'h8, 1'b0, OP_DEF);
    mreq(27'h0, 3);
    step(27'h0, 1'b0, OP_RET);
    step(27'h100, 1'b0, OP_DI);
    rd(OFS_STAT, 32'h2);
    axw(OFS_MASK, 32'h100, RESP_OKAY);
    step(27'h0, 1'b0, OP_EI);
    axw(OFS_MASK, 32'h0, RESP_OKAY);
    mreq(27'h0, 8);
    // Non-maskable inside a maskable handler, enable clear
    step(27'h0, 1'b1, OP_PLN, NMI_V, KIND_NMI, 0, LAT_HI_MIN);
    rd(OFS_STAT, 32'h4);
    step(27'h0, 1'b0, OP_EI);
    step(27'h4, 1'b1, OP_PLN);
    step(27'h0, 1'b1, OP_PLN);
    rd(OFS_STAT, 32'hD);
    step(27'h0, 1'b0, OP_RET);
    step(27'h0, 1'b0, OP_PLN, NMI_V, KIND_NMI, 0, LAT_HI_MIN);
    step(27'h0, 1'b0, OP_RET);
    step(27'h0, 1'b0, OP_PLN);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h0, 2);
    step(27'h0, 1'b0, OP_RET);
    // Software break with a maskable and a non-maskable behind it
    step(27'h20, 1'b0, OP_BRK, VEC_BRK, KIND_BRK, 0, LAT_HI_MIN);
    step(27'h0, 1'b1, OP_PLN, NMI_V, KIND_NMI, 0, LAT_HI_MIN);
    step(27'h0, 1'b0, OP_RET);
    step(27'h0, 1'b0, OP_RET);
    mreq(27'h0, 5);
    step(27'h0, 1'b0, OP_RET);
    // Random sources
    repeat (3)
    begin
      idx = $urandom_range(26, 0);
      mreq(27'h1 << idx, idx);
      step(27'h0, 1'b0, OP_RET);
    end
    `CHK(exp_q.size(), 0)
    stop_test();
  end
endmodule
